/* bench/adc_ctl_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks for the mode, clock and test control block
module adc_ctl_sva import adc_ctl_pkg::*; #(
	parameter int DATA_W = 12
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid,
	input wire logic ext_pdwn,
	input wire logic sample_strobe,
	input wire logic [2*DATA_W-1:0] out_data,
	input wire logic out_valid,
	input wire logic out_ready,
	input wire logic [1:0] chan_power_down,
	input wire logic [1:0] chan_standby,
	input wire logic digital_reset
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Recent transfer writes and pin edges; power outputs may only move after one
	logic [5:0] xfer_sh;
	logic [5:0] pin_sh;
	logic pin_d;
	wire xfer_hit = reg_wr_en && reg_addr == TRANSFER_ADDR && reg_wdata[XFER_BIT];
	wire mapped = reg_addr inside {CHAN_INDEX_ADDR, MODE_ADDR, CLOCK_ADDR, DIVIDE_ADDR, TEST_ADDR, TRANSFER_ADDR};
	// History flops; the window covers the transfer copy delay as well
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			xfer_sh <= 6'h00;
			pin_sh <= 6'h00;
			pin_d <= 1'b0;
		end else begin
			xfer_sh <= {xfer_sh[4:0], xfer_hit};
			pin_sh <= {pin_sh[4:0], ext_pdwn != pin_d};
			pin_d <= ext_pdwn;
		end
	end
	AST_RVALID_AFTER_READ: assert property (reg_rd_en |=> reg_rvalid)
		else $error("read strobe not answered next cycle");
	AST_RVALID_ONLY_READ: assert property (!reg_rd_en |=> !reg_rvalid)
		else $error("read valid without a read");
	AST_UNMAPPED_ZERO: assert property (reg_rd_en && !mapped |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	AST_RDATA_HOLDS: assert property (!reg_rvalid |-> $stable(reg_rdata))
		else $error("read data moved between reads");
	AST_OUT_HOLD: assert property (out_valid && !out_ready && xfer_sh == 6'h00 |=> out_valid && $stable(out_data))
		else $error("output word dropped before taken");
	AST_POWER_CAUSE: assert property ($changed(chan_power_down) || $changed(chan_standby) |-> xfer_sh != 6'h00 || pin_sh != 6'h00)
		else $error("power state moved without transfer or pin");
	AST_DIGRST_FLUSH: assert property ($rose(digital_reset) |-> ##[0:3] !out_valid)
		else $error("digital reset left words queued");
	AST_DIGRST_NO_PUSH: assert property (digital_reset && $past(digital_reset) |-> !sample_strobe)
		else $error("sample pushed during digital reset");
	AST_STROBE_VALID: assert property (sample_strobe && !digital_reset |=> out_valid || digital_reset)
		else $error("pushed word not offered");
	AST_RESET_STATE: assert property ($rose(rst_n) |-> chan_power_down == 2'b00 && chan_standby == 2'b00 && !out_valid)
		else $error("outputs not idle after reset");
endmodule
`default_nettype wire

/* bench/adc_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Configuration host: issues writes, reads and transfers on the register port
module adc_host_model import adc_ctl_pkg::*; (
	input wire logic ref_clk,
	output logic reg_wr_en,
	output logic reg_rd_en,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rvalid
);
	// Idle bus from time zero
	initial begin
		reg_wr_en <= 1'b0;
		reg_rd_en <= 1'b0;
		reg_addr <= 8'h00;
		reg_wdata <= 8'h00;
	end
	// One write; released lines show the inverse so stale values never pass
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_wr_en <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr_en <= 1'b0;
		reg_addr <= ~a;
		reg_wdata <= ~d;
	endtask
	// One read; data is taken at the edge that samples the valid pulse
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		@(posedge ref_clk);
		reg_rd_en <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd_en <= 1'b0;
		reg_addr <= ~a;
		@(posedge ref_clk);
		ok = reg_rvalid;
		d = reg_rdata;
	endtask
	// Point the following local writes at the chosen channels
	task automatic sel(input logic [1:0] ch);
		wr(CHAN_INDEX_ADDR, {6'h00, ch});
	endtask
	// Stage a value, copy it to the active set, then let the outputs settle
	task automatic commit(input logic [7:0] a, input logic [7:0] d);
		wr(a, d);
		wr(TRANSFER_ADDR, 8'h01);
		repeat (3) @(posedge ref_clk);
	endtask
endmodule
`default_nettype wire

/* bench/adc_mode_clock_test_control_test.sv */
`timescale 1ns/1ps
`default_nettype none
module adc_mode_clock_test_control_test import adc_ctl_pkg::*; ;
	logic ref_clk, rst_n, ext_pdwn, out_ready;
	logic [11:0] conv_a, conv_b, user1, user2;
	logic reg_wr_en, reg_rd_en, reg_rvalid, sample_strobe, out_valid, digital_reset, duty_stabilize_en;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [23:0] out_data, w0, w1;
	logic [1:0] chan_power_down, chan_standby;
	int err_count, check_count, n, d;
	logic [22:0] pn; // Reference generator state
	// Pattern table: test register value and the two words it may alternate between
	logic [7:0] tm_tab [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h08, 8'h48, 8'h09, 8'h0a, 8'h0b, 8'h0c};
	logic [23:0] a_tab [12] = '{24'h7a13c5, 24'h800800, 24'hffffff, 24'h000000, 24'haaaaaa, 24'hffffff,
		24'h123123, 24'h123123, 24'haaaaaa, 24'h03f03f, 24'h001001, 24'h50a50a};
	logic [23:0] b_tab [12] = '{24'h7a13c5, 24'h800800, 24'hffffff, 24'h000000, 24'h555555, 24'h000000,
		24'h123123, 24'h456456, 24'haaaaaa, 24'h03f03f, 24'h001001, 24'haf5af5};
	// Reset values of the four registers plus one unmapped place
	logic [7:0] ra_tab [5] = '{MODE_ADDR, CLOCK_ADDR, DIVIDE_ADDR, TEST_ADDR, 8'h20};
	logic [7:0] rv_tab [5] = '{8'h80, 8'h00, 8'h00, 8'h00, 8'h00};
	initial ref_clk = 1'b0;
	always #5 ref_clk = ~ref_clk;
	adc_mode_clock_test_control dut (.ref_clk(ref_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
		.reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.reg_rvalid(reg_rvalid), .ext_pdwn(ext_pdwn), .user_pattern1(user1), .user_pattern2(user2),
		.conv_a(conv_a), .conv_b(conv_b), .sample_strobe(sample_strobe), .out_data(out_data),
		.out_valid(out_valid), .out_ready(out_ready), .chan_power_down(chan_power_down),
		.chan_standby(chan_standby), .digital_reset(digital_reset), .duty_stabilize_en(duty_stabilize_en));
	adc_host_model host (.ref_clk(ref_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));
	// Compare and count; unknowns never match
	task automatic check(input string name, input logic [23:0] got, input logic [23:0] exp);
		check_count++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Register read with its valid pulse checked too
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		logic [7:0] v;
		logic ok;
		host.rd(a, v, ok);
		check("read valid", {23'h0, ok}, 24'h1);
		check("read data", {16'h0, v}, {16'h0, e});
	endtask
	// Next word accepted by the sink, bounded so a stall cannot hang
	task automatic take(output logic [23:0] w);
		int i;
		for (i = 0; i < 200; i++) begin
			@(posedge ref_clk);
			if (out_valid === 1'b1 && out_ready === 1'b1) break;
		end
		check("word arrived", {23'h0, i < 200}, 24'h1);
		w = out_data;
	endtask
	// Cycles between two sample strobes
	task automatic gap(output int c);
		int i;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (sample_strobe === 1'b1) break;
		end
		c = 0;
		do begin
			@(posedge ref_clk);
			c++;
		end while (sample_strobe !== 1'b1 && c < 20);
	endtask
	// Select a test mode, skip words queued before it, compare two in a row
	task automatic pat(input logic [7:0] t, input logic [23:0] a, input logic [23:0] b);
		host.commit(TEST_ADDR, t);
		repeat (8) @(posedge ref_clk);
		take(w0);
		take(w1);
		check("pattern", w0, (w0 === b) ? b : a);
		check("pattern next", w1, (w0 === b) ? a : b);
	endtask
	// Summary, verdict and end of run
	task automatic print_verdict();
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Whole run is several hundred cycles; this bound leaves wide margin
	initial begin
		repeat (20000) @(posedge ref_clk);
		err_count++;
		print_verdict();
	end
	// Main sequence
	initial begin
		rst_n <= 1'b0;
		ext_pdwn <= 1'b0;
		out_ready <= 1'b1;
		conv_a <= 12'h3c5;
		conv_b <= 12'h7a1;
		user1 <= 12'h123;
		user2 <= 12'h456;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (d = 0; d < 5; d++) rchk(ra_tab[d], rv_tab[d]);
		// Staged value must not act before the transfer
		host.wr(MODE_ADDR, 8'h01);
		repeat (4) @(posedge ref_clk);
		check("staged power", {22'h0, chan_power_down}, 24'h0);
		rchk(MODE_ADDR, 8'h80);
		for (d = 0; d < 3; d++) begin
			host.commit(MODE_ADDR, 8'(d));
			check("power down", {22'h0, chan_power_down}, (d == 1) ? 24'h3 : 24'h0);
			check("standby", {22'h0, chan_standby}, (d == 2) ? 24'h3 : 24'h0);
		end
		host.sel(2'b01);
		host.commit(MODE_ADDR, 8'h01);
		check("one channel down", {22'h0, chan_power_down}, 24'h1);
		host.sel(2'b11);
		// Pin function 00 then 01 with the pin enable set
		host.commit(MODE_ADDR, 8'h80);
		ext_pdwn <= 1'b1;
		repeat (6) @(posedge ref_clk);
		check("pin down", {22'h0, chan_power_down}, 24'h3);
		host.commit(MODE_ADDR, 8'ha0);
		repeat (6) @(posedge ref_clk);
		check("pin standby", {20'h0, chan_standby, chan_power_down}, 24'hc);
		ext_pdwn <= 1'b0;
		host.commit(MODE_ADDR, 8'h00);
		host.commit(CLOCK_ADDR, 8'h01);
		check("stabilizer", {23'h0, duty_stabilize_en}, 24'h1);
		for (d = 0; d < 8; d++) begin
			host.commit(DIVIDE_ADDR, 8'(d));
			gap(n);
			check("divide", 24'(n), 24'(d + 1));
		end
		rchk(DIVIDE_ADDR, 8'h07);
		host.commit(DIVIDE_ADDR, 8'h00);
		for (d = 0; d < 12; d++) pat(tm_tab[d], a_tab[d], b_tab[d]);
		rchk(TEST_ADDR, 8'h0c);
		// Play-once user words: one or two pattern words, then live data
		for (d = 2; d < 4; d++) begin
			host.commit(TEST_ADDR, {2'(d), 6'h08});
			n = 0;
			repeat (6) begin
				take(w0);
				n += (w0 === 24'h123123) + (w0 === 24'h456456);
			end
			check("user once", 24'(n), 24'(d - 1));
			check("then live", w0, 24'h7a13c5);
		end
		// Generator held at its seed by its reset bit, then running from the seed
		for (d = 5; d < 7; d++) begin
			host.commit(TEST_ADDR, 8'(d) | ((d == 5) ? 8'h20 : 8'h10));
			take(w0);
			check("pn held", w0, (d == 5) ? 24'hffffff : 24'h1ff1ff);
			host.commit(TEST_ADDR, 8'(d));
			pn = (d == 5) ? PN_LONG_SEED : 23'(PN_SHORT_SEED);
			n = 0;
			do begin
				take(w1);
				n++;
			end while (w1 === w0 && n < 20);
			for (n = 0; n < 4; n++) begin
				pn = (d == 5) ? {pn[21:0], pn[22] ^ pn[17]} : {14'h0, pn[7:0], pn[8] ^ pn[4]};
				check("pn word", w1, (d == 5) ? {2{pn[11:0]}} : {2{3'h0, pn[8:0]}});
				take(w1);
			end
		end
		// Stall the sink, flush by digital reset, then fill until refused
		out_ready <= 1'b0;
		host.commit(MODE_ADDR, 8'h03);
		@(posedge ref_clk); // The flush lands one edge after the reset output rises
		check("digital reset", {22'h0, digital_reset, out_valid}, 24'h2);
		host.commit(MODE_ADDR, 8'h00);
		repeat (60) @(posedge ref_clk);
		n = 0;
		repeat (20) @(posedge ref_clk) n += (sample_strobe === 1'b1);
		check("full refuses", 24'(n), 24'h0);
		host.commit(MODE_ADDR, 8'h01);
		out_ready <= 1'b1;
		n = 0;
		repeat (60) @(posedge ref_clk) n += (out_valid === 1'b1 && out_ready === 1'b1);
		check("fifo depth", 24'(n), 24'(FIFO_DEPTH));
		print_verdict();
	end
endmodule
bind adc_mode_clock_test_control adc_ctl_sva #(.DATA_W(DATA_W)) chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .ext_pdwn(ext_pdwn), .sample_strobe(sample_strobe),
	.out_data(out_data), .out_valid(out_valid), .out_ready(out_ready), .chan_power_down(chan_power_down),
	.chan_standby(chan_standby), .digital_reset(digital_reset));
`default_nettype wire

/* core/adc_ctl_pkg.sv */
package adc_ctl_pkg;

	// Register offsets on the configuration port
	localparam logic [7:0] CHAN_INDEX_ADDR = 8'h05;
	localparam logic [7:0] MODE_ADDR = 8'h08;
	localparam logic [7:0] CLOCK_ADDR = 8'h09;
	localparam logic [7:0] DIVIDE_ADDR = 8'h0b;
	localparam logic [7:0] TEST_ADDR = 8'h0d;
	localparam logic [7:0] TRANSFER_ADDR = 8'hff;

	// Reset values
	localparam logic [7:0] CHAN_INDEX_RST = 8'h03;
	localparam logic [7:0] MODE_RST = 8'h80;
	localparam logic [7:0] CLOCK_RST = 8'h00;
	localparam logic [7:0] DIVIDE_RST = 8'h00;
	localparam logic [7:0] TEST_RST = 8'h00;

	// Field positions in the mode register
	localparam int EXT_PD_EN_BIT = 7;
	localparam int PIN_FUNC_LSB = 5;
	localparam int PWR_MODE_LSB = 0;
	// Field positions elsewhere
	localparam int DCS_BIT = 0;
	localparam int DIV_LSB = 0;
	localparam int XFER_BIT = 0;
	localparam int USER_MODE_LSB = 6;
	localparam int PN_LONG_RST_BIT = 5;
	localparam int PN_SHORT_RST_BIT = 4;
	localparam int TEST_MODE_LSB = 0;

	// Power mode field codes
	localparam logic [1:0] PWR_RUN = 2'h0;
	localparam logic [1:0] PWR_DOWN = 2'h1;
	localparam logic [1:0] PWR_STANDBY = 2'h2;
	localparam logic [1:0] PWR_DIG_RESET = 2'h3;
	// External pin function codes
	localparam logic [1:0] PIN_FULL_DOWN = 2'h0;
	localparam logic [1:0] PIN_STANDBY = 2'h1;

	// Output test mode codes
	typedef enum logic [3:0] {
		TM_OFF = 4'h0, TM_MIDSCALE = 4'h1, TM_POS_FS = 4'h2, TM_NEG_FS = 4'h3,
		TM_CHECKER = 4'h4, TM_PN_LONG = 4'h5, TM_PN_SHORT = 4'h6, TM_WORD_TOGGLE = 4'h7,
		TM_USER = 4'h8, TM_BIT_TOGGLE = 4'h9, TM_SYNC = 4'ha, TM_ONE_BIT = 4'hb,
		TM_MIXED = 4'hc
	} test_mode_t;

	// Fixed test words for the 12-bit offset-binary output
	localparam logic [11:0] WORD_MID = 12'h800;
	localparam logic [11:0] WORD_POS_FS = 12'hfff;
	localparam logic [11:0] WORD_NEG_FS = 12'h000;
	localparam logic [11:0] WORD_CHECK_A = 12'haaa;
	localparam logic [11:0] WORD_CHECK_B = 12'h555;
	localparam logic [11:0] WORD_ONES = 12'hfff;
	localparam logic [11:0] WORD_ZEROS = 12'h000;
	localparam logic [11:0] WORD_BIT_TOGGLE = 12'haaa;
	localparam logic [11:0] WORD_SYNC = 12'h03f;
	localparam logic [11:0] WORD_ONE_BIT = 12'h001;
	localparam logic [11:0] WORD_MIXED_A = 12'h50a;
	localparam logic [11:0] WORD_MIXED_B = 12'haf5;

	// Pseudo-random generator lengths and seeds
	localparam int PN_LONG_LEN = 23;
	localparam int PN_SHORT_LEN = 9;
	localparam logic [22:0] PN_LONG_SEED = 23'h7fffff;
	localparam logic [8:0] PN_SHORT_SEED = 9'h1ff;

	// Data path FIFO shape
	localparam int FIFO_DEPTH = 32;

endpackage

/* core/adc_mode_clock_test_control.sv */
`timescale 1ns/1ps
`default_nettype none

module adc_mode_clock_test_control import adc_ctl_pkg::*; #(
	parameter int DATA_W = 12,
	parameter int DEPTH = FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	input wire logic ext_pdwn,
	input wire logic [DATA_W-1:0] user_pattern1,
	input wire logic [DATA_W-1:0] user_pattern2,
	input wire logic [DATA_W-1:0] conv_a,
	input wire logic [DATA_W-1:0] conv_b,
	output logic sample_strobe,
	output logic [2*DATA_W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [1:0] chan_power_down,
	output logic [1:0] chan_standby,
	output logic digital_reset,
	output logic duty_stabilize_en
);

	// Power decode: bit 1 is standby, bit 0 is full power-down
	function automatic logic [1:0] power_state(input logic [7:0] mode, input logic pin);
		logic [1:0] pm;
		logic [1:0] fn;
		pm = mode[PWR_MODE_LSB +: 2];
		fn = mode[PIN_FUNC_LSB +: 2];
		power_state = 2'h0;
		if (pm == PWR_DOWN) begin
			power_state = 2'h1;
		end else if (pm == PWR_STANDBY) begin
			power_state = 2'h2;
		end
		// The pin only adds a state; a register power-down still wins
		if (mode[EXT_PD_EN_BIT] && pin && power_state == 2'h0) begin
			power_state = (fn == PIN_STANDBY) ? 2'h2 : 2'h1;
		end
	endfunction

	// Test word decode; codes above the table fall back to live data
	function automatic logic [DATA_W-1:0] pattern_word(
		input logic [3:0] tm,
		input logic phase,
		input logic [1:0] umode,
		input logic [DATA_W-1:0] pn_long,
		input logic [DATA_W-1:0] pn_short,
		input logic [DATA_W-1:0] u1,
		input logic [DATA_W-1:0] u2,
		input logic [DATA_W-1:0] live
	);
		case (test_mode_t'(tm))
			TM_MIDSCALE: pattern_word = WORD_MID;
			TM_POS_FS: pattern_word = WORD_POS_FS;
			TM_NEG_FS: pattern_word = WORD_NEG_FS;
			TM_CHECKER: pattern_word = phase ? WORD_CHECK_B : WORD_CHECK_A;
			TM_PN_LONG: pattern_word = pn_long;
			TM_PN_SHORT: pattern_word = pn_short;
			TM_WORD_TOGGLE: pattern_word = phase ? WORD_ZEROS : WORD_ONES;
			TM_USER: pattern_word = (umode[0] && phase) ? u2 : u1;
			TM_BIT_TOGGLE: pattern_word = WORD_BIT_TOGGLE;
			TM_SYNC: pattern_word = WORD_SYNC;
			TM_ONE_BIT: pattern_word = WORD_ONE_BIT;
			TM_MIXED: pattern_word = phase ? WORD_MIXED_B : WORD_MIXED_A;
			default: pattern_word = live;
		endcase
	endfunction

	// Global and index registers
	logic [7:0] chan_sel_reg; // Channels that take local writes
	logic [7:0] clk_mst_reg; // Clock options, pending
	logic [7:0] div_mst_reg; // Divide ratio, pending
	logic [7:0] div_act_reg; // Divide ratio, in force
	logic xfer_reg; // Transfer bit, cleared by hardware next cycle
	logic [2:0] div_cnt_reg; // Sample clock divider
	logic [1:0][7:0] mode_act_w; // Per-channel mode in force
	logic [1:0][7:0] test_act_w; // Per-channel test mode in force
	logic [1:0][DATA_W-1:0] chan_word_w; // Per-channel output word
	logic [1:0][1:0] pwr_w; // Per-channel power decode
	wire logic fifo_in_ready; // Room in the output FIFO
	wire logic div_tick; // One pulse per divided sample clock
	wire logic push; // A sample word enters the FIFO
	wire logic any_running; // At least one channel converting
	wire logic dig_reset_req; // A channel holds the reset code
	wire logic wr_mode;
	wire logic wr_test;
	wire logic wr_clock;
	wire logic wr_div;
	wire logic wr_index;
	wire logic wr_xfer;
	wire logic rd_ch; // Channel shown on local register reads
	logic [7:0] rd_word; // Read mux

	// Unmapped addresses raise no strobe, so such writes simply vanish
	// Write strobes
	assign wr_mode = reg_wr_en && (reg_addr == MODE_ADDR);
	assign wr_test = reg_wr_en && (reg_addr == TEST_ADDR);
	assign wr_clock = reg_wr_en && (reg_addr == CLOCK_ADDR);
	assign wr_div = reg_wr_en && (reg_addr == DIVIDE_ADDR);
	assign wr_index = reg_wr_en && (reg_addr == CHAN_INDEX_ADDR);
	assign wr_xfer = reg_wr_en && (reg_addr == TRANSFER_ADDR) && reg_wdata[XFER_BIT];

	// Divider: tick when the count reaches the programmed value
	assign div_tick = (div_cnt_reg == div_act_reg[DIV_LSB +: 3]);
	assign any_running = (pwr_w[0] == 2'h0) || (pwr_w[1] == 2'h0);
	assign dig_reset_req = (mode_act_w[0][PWR_MODE_LSB +: 2] == PWR_DIG_RESET) ||
		(mode_act_w[1][PWR_MODE_LSB +: 2] == PWR_DIG_RESET);
	// A full FIFO holds the generators still rather than skipping words
	assign push = div_tick && fifo_in_ready && any_running && !digital_reset;

	// Local reads show channel A when selected, otherwise channel B
	// Reads show the copy in force, except the clock register which shows its pending copy, so a staged mode, divide or test value stays hidden until transfer
	assign rd_ch = ~chan_sel_reg[0];
	always_comb begin
		case (reg_addr)
			CHAN_INDEX_ADDR: rd_word = chan_sel_reg;
			MODE_ADDR: rd_word = mode_act_w[rd_ch];
			CLOCK_ADDR: rd_word = clk_mst_reg;
			DIVIDE_ADDR: rd_word = div_act_reg;
			TEST_ADDR: rd_word = test_act_w[rd_ch];
			TRANSFER_ADDR: rd_word = {7'h00, xfer_reg};
			default: rd_word = 8'h00;
		endcase
	end

	// Index register; the default selects both channels
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_sel_reg <= CHAN_INDEX_RST;
		end else if (wr_index) begin
			chan_sel_reg <= {6'h00, reg_wdata[1:0]};
		end
	end

	// Global masters take writes at once
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			clk_mst_reg <= CLOCK_RST;
			div_mst_reg <= DIVIDE_RST;
		end else begin
			if (wr_clock) begin
				clk_mst_reg <= {7'h00, reg_wdata[DCS_BIT]};
			end
			if (wr_div) begin
				div_mst_reg <= {5'h00, reg_wdata[DIV_LSB +: 3]};
			end
		end
	end

	// Transfer bit: set by the host, dropped by hardware after the copy
	// A write in the clearing cycle sets it again, so back-to-back transfers both land
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			xfer_reg <= 1'b0;
		end else begin
			xfer_reg <= wr_xfer;
		end
	end

	// Global slaves follow the masters only on transfer
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_act_reg <= DIVIDE_RST;
			duty_stabilize_en <= CLOCK_RST[DCS_BIT];
		end else if (xfer_reg) begin
			div_act_reg <= div_mst_reg;
			duty_stabilize_en <= clk_mst_reg[DCS_BIT];
		end
	end

	// Divider counter; restarted by the digital reset and on a new ratio
	// Restarting keeps the first tick after a change a full period away
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			div_cnt_reg <= 3'h0;
		end else if (digital_reset || xfer_reg || div_tick) begin
			div_cnt_reg <= 3'h0;
		end else begin
			div_cnt_reg <= div_cnt_reg + 3'h1;
		end
	end

	// Per-channel local registers and test generators
	for (genvar ch = 0; ch < 2; ch++) begin : g_chan
		logic [7:0] mode_mst_reg; // Mode, pending
		logic [7:0] mode_act_reg; // Mode, in force
		logic [7:0] test_mst_reg; // Test mode, pending
		logic [7:0] test_act_reg; // Test mode, in force
		logic [PN_LONG_LEN-1:0] pn_long_reg; // Long sequence generator
		logic [PN_SHORT_LEN-1:0] pn_short_reg; // Short sequence generator
		logic phase_reg; // Alternates each emitted word
		logic once_done_reg; // A play-once user pattern has finished
		wire logic [3:0] tm;
		wire logic [1:0] umode;
		wire logic test_on;
		wire logic restart;
		wire logic [DATA_W-1:0] live;

		assign tm = test_act_reg[TEST_MODE_LSB +: 4];
		assign umode = test_act_reg[USER_MODE_LSB +: 2];
		// Test data is active for every listed code except TM_OFF and a spent one-shot
		assign test_on = (tm != TM_OFF) && (tm <= TM_MIXED) &&
			!((tm == TM_USER) && umode[1] && once_done_reg);
		assign restart = digital_reset || xfer_reg;
		assign live = (ch == 0) ? conv_a : conv_b;
		assign mode_act_w[ch] = mode_act_reg;
		assign test_act_w[ch] = test_act_reg;
		assign pwr_w[ch] = power_state(mode_act_reg, ext_pdwn);
		// A quiet channel sends zeros; test data otherwise overrides live data
		assign chan_word_w[ch] = (pwr_w[ch] != 2'h0) ? '0 : test_on ?
			pattern_word(tm, phase_reg, umode, pn_long_reg[DATA_W-1:0],
				{3'h0, pn_short_reg}, user_pattern1, user_pattern2, live) : live;

		// Master copies take writes only for selected channels
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				mode_mst_reg <= MODE_RST;
				test_mst_reg <= TEST_RST;
			end else begin
				if (wr_mode && chan_sel_reg[ch]) begin
					mode_mst_reg <= {reg_wdata[7:5], 3'h0, reg_wdata[1:0]};
				end
				if (wr_test && chan_sel_reg[ch]) begin
					test_mst_reg <= reg_wdata;
				end
			end
		end

		// Active copies change only on transfer
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				mode_act_reg <= MODE_RST;
				test_act_reg <= TEST_RST;
			end else if (xfer_reg) begin
				mode_act_reg <= mode_mst_reg;
				test_act_reg <= test_mst_reg;
			end
		end

		// Long generator: held at seed while its reset bit is set
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				pn_long_reg <= PN_LONG_SEED;
			end else if (restart || test_act_reg[PN_LONG_RST_BIT]) begin
				pn_long_reg <= PN_LONG_SEED;
			end else if (push) begin
				pn_long_reg <= {pn_long_reg[21:0], pn_long_reg[22] ^ pn_long_reg[17]};
			end
		end

		// Short generator: same scheme, nine stages
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				pn_short_reg <= PN_SHORT_SEED;
			end else if (restart || test_act_reg[PN_SHORT_RST_BIT]) begin
				pn_short_reg <= PN_SHORT_SEED;
			end else if (push) begin
				pn_short_reg <= {pn_short_reg[7:0], pn_short_reg[8] ^ pn_short_reg[4]};
			end
		end

		// Word phase and one-shot tracking
		always_ff @(posedge ref_clk or negedge rst_n) begin
			if (!rst_n) begin
				phase_reg <= 1'b0;
				once_done_reg <= 1'b0;
			end else if (restart) begin
				phase_reg <= 1'b0;
				once_done_reg <= 1'b0;
			end else if (push) begin
				phase_reg <= ~phase_reg;
				// Single once ends after one word, alternating once after two
				if (tm == TM_USER && umode[1] && (!umode[0] || phase_reg)) begin
					once_done_reg <= 1'b1;
				end
			end
		end
	end

	// Status outputs and read answer
	// Read data loads only on a read, so it holds between reads
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			chan_power_down <= 2'h0;
			chan_standby <= 2'h0;
			digital_reset <= 1'b0;
			sample_strobe <= 1'b0;
			reg_rdata <= 8'h00;
			reg_rvalid <= 1'b0;
		end else begin
			chan_power_down <= {pwr_w[1][0], pwr_w[0][0]};
			chan_standby <= {pwr_w[1][1], pwr_w[0][1]};
			digital_reset <= dig_reset_req;
			sample_strobe <= push;
			reg_rvalid <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rdata <= rd_word;
			end
		end
	end

	// Output buffer; channel B in the upper half
	// The flush follows the registered reset, so a word pushed just before it goes too
	sample_fifo #(
		.WIDTH(2*DATA_W),
		.DEPTH(DEPTH)
	) u_fifo (
		.clk(ref_clk),
		.rst_n(rst_n),
		.flush(digital_reset),
		.in_valid(push),
		.in_ready(fifo_in_ready),
		.in_data({chan_word_w[1], chan_word_w[0]}),
		.out_valid(out_valid),
		.out_ready(out_ready),
		.out_data(out_data)
	);

endmodule

`default_nettype wire

/* core/sample_fifo.sv */
`timescale 1ns/1ps
`default_nettype none

// Small FIFO with registered read data and registered ready
module sample_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic flush,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem [DEPTH]; // Storage, no reset needed
	logic [AW-1:0] wr_ptr_reg; // Next slot to fill
	logic [AW-1:0] rd_ptr_reg; // Next slot to drain
	logic [AW:0] cnt_reg; // Words held in storage, output stage excluded
	wire logic wr_go;
	wire logic rd_go;
	wire logic [AW:0] cnt_next;
	wire logic out_valid_next; // Output stage occupied after this edge
	wire logic [AW:0] fill_next; // Words held after this edge, output stage included

	// Ready is registered, so it looks one word ahead of the count
	assign wr_go = in_valid & in_ready;
	assign rd_go = (cnt_reg != '0) & (~out_valid | out_ready);
	assign cnt_next = cnt_reg + (AW+1)'(wr_go) - (AW+1)'(rd_go);
	assign out_valid_next = rd_go | (out_valid & ~out_ready);
	// The output stage counts against the depth, so no more than DEPTH words are ever held
	assign fill_next = cnt_next + (AW+1)'(out_valid_next);

	// Storage write, kept out of the reset process
	always_ff @(posedge clk) begin
		if (wr_go) begin
			mem[wr_ptr_reg] <= in_data;
		end
	end

	// Pointers, count and output stage
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
			out_data <= '0;
		end else if (flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			cnt_reg <= '0;
			in_ready <= 1'b1;
			out_valid <= 1'b0;
		end else begin
			if (wr_go) begin
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
			if (rd_go) begin
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
				out_data <= mem[rd_ptr_reg];
			end
			cnt_reg <= cnt_next;
			in_ready <= (fill_next < (AW+1)'(DEPTH));
			out_valid <= out_valid_next;
		end
	end

endmodule

`default_nettype wire
